// ---- asr_pkg.sv ----
// package of timing constants and states for the static ram controller
package asr_pkg;
    localparam int CLK_PERIOD_NS   = 20;
    localparam int ADDR_W          = 15;
    localparam int DATA_W          = 8;
    // fastest grade figures in ns
    localparam int T_RC_NS         = 70;
    localparam int T_AA_NS         = 70;
    localparam int T_OE_NS         = 35;
    localparam int T_OHZ_NS        = 30;
    localparam int T_WC_NS         = 70;
    localparam int T_AW_NS         = 50;
    localparam int T_WP_NS         = 55;
    localparam int T_DW_NS         = 30;
    localparam int T_WHZ_NS        = 30;
    localparam int T_OW_NS         = 10;
    // least times round up, longest waits for data round up as well
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int RD_CYC          = cyc_up(T_AA_NS) + 1;
    localparam int WP_CYC          = cyc_up(T_WP_NS);
    localparam int OHZ_CYC         = cyc_up(T_OHZ_NS);
    localparam int SYNC_CYC        = 2;
    localparam int REL_CYC         = 1;
    localparam int CNT_W           = 4;
    typedef enum logic [2:0] {
        ASR_IDLE,
        ASR_RD,
        ASR_RD_END,
        ASR_WR_SETUP,
        ASR_WR_PULSE,
        ASR_WR_END
    } asr_state_t;
endpackage

// ---- asr_sync.sv ----
// two flop synchroniser for the returning data pins
`timescale 1ns/1ps
module asr_sync #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] m_q;
    logic [W-1:0] m_d;
    logic [W-1:0] q_d;
    always_comb begin
        m_d = d;
        q_d = m_q;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            m_q <= '0;
            q   <= '0;
        end else begin
            m_q <= m_d;
            q   <= q_d;
        end
    end
endmodule // asr_sync

// ---- asr_ctrl.sv ----
// controller that drives a byte wide asynchronous static ram
// Behaviour
// - a write happens only while chip select and write enable are both low.
// - hold output enable high whenever memory data pins must float.
// - keep chip select or write enable high while address changes.
// - hold write enable high throughout every read cycle.
// - never drive the data lines while the memory drives them.
// - each read cycle lasts at least 70 ns.
// - address and select valid at least 50 ns before write ends.
// - write pulse at least 55 ns, write cycle at least 70 ns.
// - write data valid 30 ns before write end, zero hold.
`timescale 1ns/1ps
module asr_ctrl
    import asr_pkg::*;
#(
    parameter int AW      = ADDR_W,
    parameter int DW      = DATA_W,
    parameter int RD_WAIT = RD_CYC,
    parameter int WP_WAIT = WP_CYC,
    parameter int HZ_WAIT = OHZ_CYC
) (
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          req_valid,
    input  wire logic          req_write,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [DW-1:0] req_wdata,
    output logic               req_ready,
    output logic               rsp_valid,
    output logic      [DW-1:0] rsp_rdata,
    output logic      [AW-1:0] mem_addr,
    output logic               mem_cs_n,
    output logic               mem_oe_n,
    output logic               mem_we_n,
    input  wire logic [DW-1:0] mem_dq_in,
    output logic      [DW-1:0] mem_dq_out,
    output logic               mem_dq_oe_n
);
    asr_state_t       st_q;
    asr_state_t       st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [AW-1:0]    addr_q;
    logic [AW-1:0]    addr_d;
    logic [DW-1:0]    wd_q;
    logic [DW-1:0]    wd_d;
    logic [DW-1:0]    rd_q;
    logic [DW-1:0]    rd_d;
    logic             cs_n_q;
    logic             cs_n_d;
    logic             oe_n_q;
    logic             oe_n_d;
    logic             we_n_q;
    logic             we_n_d;
    logic             dqoe_n_q;
    logic             dqoe_n_d;
    logic             rv_q;
    logic             rv_d;
    logic [DW-1:0]    dq_s;

    asr_sync #(.W(DW)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        (mem_dq_in),
        .q        (dq_s)
    );

    function automatic logic [CNT_W-1:0] cnt_of(input int n);
        return CNT_W'(n - 1);
    endfunction

    function automatic logic cnt_done(input logic [CNT_W-1:0] c);
        return c == '0;
    endfunction

    function automatic logic [CNT_W-1:0] cnt_dec(input logic [CNT_W-1:0] c);
        return c - 1'b1;
    endfunction

    assign req_ready   = (st_q == ASR_IDLE);
    assign rsp_valid   = rv_q;
    assign rsp_rdata   = rd_q;
    assign mem_addr    = addr_q;
    assign mem_cs_n    = cs_n_q;
    assign mem_oe_n    = oe_n_q;
    assign mem_we_n    = we_n_q;
    assign mem_dq_out  = wd_q;
    assign mem_dq_oe_n = dqoe_n_q;

    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q;
        addr_d   = addr_q;
        wd_d     = wd_q;
        rd_d     = rd_q;
        cs_n_d   = cs_n_q;
        oe_n_d   = oe_n_q;
        we_n_d   = we_n_q;
        dqoe_n_d = dqoe_n_q;
        rv_d     = 1'b0;
        case (st_q)
            ASR_IDLE: begin
                cs_n_d   = 1'b1;
                we_n_d   = 1'b1;
                oe_n_d   = 1'b1;
                dqoe_n_d = 1'b1;
                if (req_valid) begin
                    // address moves only while write enable is high; on a read select falls on the same edge
                    addr_d = req_addr;
                    wd_d   = req_wdata;
                    if (req_write) begin
                        st_d  = ASR_WR_SETUP;
                    end else begin
                        cs_n_d = 1'b0;
                        oe_n_d = 1'b0;
                        we_n_d = 1'b1;
                        cnt_d  = cnt_of(RD_WAIT);
                        st_d   = ASR_RD;
                    end
                end
            end
            ASR_RD: begin
                dqoe_n_d = 1'b1;
                we_n_d   = 1'b1;
                if (cnt_done(cnt_q)) begin
                    // sample after access time plus synchroniser delay
                    st_d   = ASR_RD_END;
                    cnt_d  = cnt_of(SYNC_CYC);
                end else begin
                    cnt_d = cnt_dec(cnt_q);
                end
            end
            ASR_RD_END: begin
                dqoe_n_d = 1'b1;
                we_n_d   = 1'b1;
                if (cnt_done(cnt_q)) begin
                    rd_d   = dq_s;
                    rv_d   = 1'b1;
                    cs_n_d = 1'b1;
                    oe_n_d = 1'b1;
                    cnt_d  = cnt_of(HZ_WAIT);
                    st_d   = ASR_WR_END;
                end else begin
                    cnt_d = cnt_dec(cnt_q);
                end
            end
            ASR_WR_SETUP: begin
                // select and write enable fall together so memory never drives
                cs_n_d   = 1'b0;
                we_n_d   = 1'b0;
                oe_n_d   = 1'b1;
                cnt_d    = cnt_of(WP_WAIT);
                st_d     = ASR_WR_PULSE;
            end
            ASR_WR_PULSE: begin
                // drive data one cycle after write enable falls
                dqoe_n_d = 1'b0;
                oe_n_d   = 1'b1;
                if (cnt_done(cnt_q)) begin
                    we_n_d = 1'b1;
                    cs_n_d = 1'b1;
                    cnt_d  = cnt_of(REL_CYC);
                    st_d   = ASR_WR_END;
                end else begin
                    cnt_d = cnt_dec(cnt_q);
                end
            end
            ASR_WR_END: begin
                // data released one cycle after the write ends, which meets zero hold
                dqoe_n_d = 1'b1;
                oe_n_d   = 1'b1;
                if (cnt_done(cnt_q)) begin
                    st_d = ASR_IDLE;
                end else begin
                    cnt_d = cnt_dec(cnt_q);
                end
            end
            default: begin
                st_d     = ASR_IDLE;
                cs_n_d   = 1'b1;
                oe_n_d   = 1'b1;
                we_n_d   = 1'b1;
                dqoe_n_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q     <= ASR_IDLE;
            cnt_q    <= '0;
            addr_q   <= '0;
            wd_q     <= '0;
            rd_q     <= '0;
            cs_n_q   <= 1'b1;
            oe_n_q   <= 1'b1;
            we_n_q   <= 1'b1;
            dqoe_n_q <= 1'b1;
            rv_q     <= 1'b0;
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            addr_q   <= addr_d;
            wd_q     <= wd_d;
            rd_q     <= rd_d;
            cs_n_q   <= cs_n_d;
            oe_n_q   <= oe_n_d;
            we_n_q   <= we_n_d;
            dqoe_n_q <= dqoe_n_d;
            rv_q     <= rv_d;
        end
    end
endmodule // asr_ctrl

// ---- asr_ctrl_monitor.sv ----
// checker for the static ram controller pins
`timescale 1ns/1ps
module asr_ctrl_monitor (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        rsp_valid,
    input wire logic [14:0] mem_addr,
    input wire logic        mem_cs_n,
    input wire logic        mem_oe_n,
    input wire logic        mem_we_n,
    input wire logic        mem_dq_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_rd_we_hi: assert property (!mem_oe_n |-> mem_we_n && !mem_cs_n)
        else $error("we low in read");
    a_addr_hold: assert property (!$stable(mem_addr) |-> $past(mem_cs_n | mem_we_n)
        && (mem_cs_n | mem_we_n)) else $error("addr moved in cycle");
    a_no_clash: assert property (!mem_dq_oe_n |-> mem_oe_n && $past(mem_oe_n, 2))
        else $error("data clash");
    a_oe_off_wr: assert property (!mem_we_n |-> mem_oe_n)
        else $error("oe low in write");
    a_cs_we_fall: assert property ($fell(mem_we_n) |-> $fell(mem_cs_n))
        else $error("cs not with we");
    a_wr_pulse: assert property ($fell(mem_we_n) |-> !mem_we_n [*3] ##1 mem_we_n)
        else $error("write pulse");
    a_wr_data: assert property ($rose(mem_we_n) |-> !mem_dq_oe_n && !$past(mem_dq_oe_n, 2))
        else $error("write data");
    a_wr_gap: assert property ($rose(mem_we_n) |-> mem_we_n [*3])
        else $error("write cycle");
    a_rd_len: assert property ($fell(mem_oe_n) |-> !mem_oe_n [*7] ##1 mem_oe_n && rsp_valid)
        else $error("read cycle");
    c_write: cover property ($fell(mem_we_n));
    c_read: cover property (rsp_valid);
    c_wr_rd: cover property ($rose(mem_we_n) ##[1:8] $fell(mem_oe_n));
endmodule // asr_ctrl_monitor
bind asr_ctrl asr_ctrl_monitor asr_ctrl_monitor_i (.core_clk, .rst, .rsp_valid,
    .mem_addr, .mem_cs_n, .mem_oe_n, .mem_we_n, .mem_dq_oe_n);

// ---- asr_sram_model.sv ----
// behavioural model of the byte wide static ram
`timescale 1ns/1ps
module asr_sram_model #(
    parameter int ACC = 70
) (
    input  wire logic [14:0] addr,
    input  wire logic        cs_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [7:0]  din,
    output logic      [7:0]  dout
);
    logic [7:0]  mem [0:32767];
    logic [14:0] addr_d;
    logic        rd;
    logic        on;
    logic        ok;
    always @* if (!cs_n && !we_n) mem[addr] = din;
    assign rd = !cs_n && we_n && !oe_n;
    assign #10 on = rd;
    assign #(ACC) ok = rd;
    assign #10 addr_d = addr;
    // floating pins show the inverse of the byte
    assign dout = (on && ok) ? mem[addr_d] : ~mem[addr_d];
endmodule // asr_sram_model

// ---- asr_ctrl_tb.sv ----
// testbench for the static ram controller against a memory model
`timescale 1ns/1ps
module asr_ctrl_tb;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [14:0] req_addr = 15'h0000;
    logic [7:0]  req_wdata = 8'h00;
    logic        req_ready, rsp_valid, mem_cs_n, mem_oe_n, mem_we_n, mem_dq_oe_n;
    logic [7:0]  rsp_rdata, mem_dq_out, mem_dq_in, dq_m;
    logic [14:0] mem_addr;
    logic [14:0] adr [4] = '{15'h0000, 15'h7fff, 15'h2aaa, 15'h0000};
    logic [7:0]  dat [4] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3};
    int          errors = 0;
    int          cmp_count = 0;
    always #10 core_clk = ~core_clk;
    assign mem_dq_in = mem_dq_oe_n ? dq_m : mem_dq_out;
    asr_ctrl asr_ctrl_i (.core_clk, .rst, .req_valid, .req_write, .req_addr, .req_wdata,
        .req_ready, .rsp_valid, .rsp_rdata, .mem_addr, .mem_cs_n, .mem_oe_n,
        .mem_we_n, .mem_dq_in, .mem_dq_out, .mem_dq_oe_n);
    asr_sram_model asr_sram_model_i (.addr(mem_addr), .cs_n(mem_cs_n), .oe_n(mem_oe_n),
        .we_n(mem_we_n), .din(mem_dq_oe_n ? ~mem_dq_out : mem_dq_out), .dout(dq_m));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        int n;
        n = 0;
        @(posedge core_clk) #1;
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1 && n++ < 20) @(posedge core_clk) #1;
        @(posedge core_clk) #1;
        req_valid = 1'b0;
        chk({7'h00, req_ready}, 8'h00);
        while (!w && rsp_valid !== 1'b1 && n++ < 20) @(posedge core_clk) #1;
        q = rsp_rdata;
        if (n > 20) begin
            errors++;
            $display("[ERR] %0t request timed out", $time);
            test_done();
        end
    endtask
    task automatic t_idle;
        chk({4'h0, mem_cs_n, mem_oe_n, mem_we_n, mem_dq_oe_n}, 8'h0f);
    endtask
    task automatic t_edges;
        logic [7:0] q;
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, adr[i], dat[i], q);
        end
        for (int i = 1; i < 4; i++) begin
            xfer(1'b0, adr[i], 8'h00, q);
            chk(q, dat[i]);
        end
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        rst = 1'b0;
        t_idle();
        t_edges();
        test_done();
    end
endmodule // asr_ctrl_tb
